/* File: inc/lpm_pkg.sv */
// Package of shared constants and carriers for the low power mode controller
package lpm_pkg;
    localparam int CTRL_W = 8;
    localparam int IDLE_POS = 0;
    localparam int PDOWN_POS = 1;
    localparam int GF0_POS = 2;
    localparam int GF1_POS = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int OSC_PER_MCYCLE = 12;
    localparam int RESET_MCYCLES = 2;
    localparam int RESET_OSC_PERIODS = OSC_PER_MCYCLE * RESET_MCYCLES;
    localparam int WAKE_SETTLE_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_IDLE,
        LPM_PDOWN,
        LPM_OSC_START,
        LPM_WAKE_DONE
    } lpm_mode_t;

    // Software write to the power control register
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } lpm_ctrl_wr_t;

    // Pin drive values while running
    typedef struct packed {
        logic ale;
        logic pss;
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] p2_out;
    } lpm_pins_t;
endpackage

/* File: src/lpm_ctrl.sv */
// Idle and power-down mode controller for the 8-bit core
`timescale 1ns/100ps
module lpm_ctrl #(
    parameter int SETTLE_CYC = lpm_pkg::WAKE_SETTLE_CYC,
    parameter int RESET_HOLD = lpm_pkg::RESET_OSC_PERIODS
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire lpm_pkg::lpm_ctrl_wr_t CTRL_WR,
    input wire logic INSTR_DONE,
    input wire logic IRQ_PENDING,
    input wire logic IRQ_VECTOR,
    input wire logic EXT_IRQ_A_N,
    input wire logic EXT_IRQ_B_N,
    input wire logic EXT_IRQ_A_EN,
    input wire logic EXT_IRQ_B_EN,
    input wire logic IRQ_B_HIGHER,
    input wire logic EXT_PROG_MEM,
    input wire logic RST_PIN,
    input wire lpm_pkg::lpm_pins_t RUN_PINS,
    input wire logic [7:0] P2_ADDR,
    output logic [7:0] POWER_CTRL_REG,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic OSC_EN,
    output logic MEM_WRITE_BLOCK,
    output logic SFR_INIT,
    output logic CORE_RESET,
    output logic WAKE_IRQ_A,
    output logic WAKE_IRQ_B,
    output lpm_pkg::lpm_pins_t PIN_DRIVE,
    output logic [2:0] MODE
);
    typedef struct packed {
        lpm_pkg::lpm_mode_t mode;
        logic [7:0] ctrl;
        logic [15:0] settle;
        logic wake_a;
        logic wake_b;
        logic wake_pulse_a;
        logic wake_pulse_b;
        logic [7:0] held_p0;
        logic [7:0] held_p0_oe;
        logic [7:0] held_p2;
        logic sfr_init;
    } lpm_state_t;

    lpm_state_t st;
    lpm_state_t next_st;
    logic osc_tick;
    logic rst_done;
    logic a_low;
    logic b_low;

    function automatic logic bit_of(input logic [7:0] r, input int pos);
        return r[pos];
    endfunction

    function automatic logic cpu_running(input lpm_pkg::lpm_mode_t m);
        return m == lpm_pkg::LPM_RUN;
    endfunction

    function automatic logic osc_stopped(input lpm_pkg::lpm_mode_t m);
        return m == lpm_pkg::LPM_PDOWN;
    endfunction

    // Enabled wake pins only
    assign a_low = EXT_IRQ_A_EN && !EXT_IRQ_A_N;
    assign b_low = EXT_IRQ_B_EN && !EXT_IRQ_B_N;

    // Reset counting needs a running oscillator; during power-down it waits
    assign osc_tick = !osc_stopped(st.mode);

    lpm_reset_stretch #(
        .HOLD(RESET_HOLD)
    ) u_rst (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .osc_tick(osc_tick),
        .rst_req(RST_PIN),
        .rst_done(rst_done)
    );

    always_comb begin
        next_st = st;
        next_st.wake_pulse_a = 1'b0;
        next_st.wake_pulse_b = 1'b0;
        next_st.sfr_init = 1'b0;
        if (rst_done) begin
            // Reset leaves any mode and reinitialises registers, RAM untouched
            next_st.mode = lpm_pkg::LPM_RUN;
            next_st.ctrl = lpm_pkg::CTRL_RESET;
            next_st.sfr_init = 1'b1;
            next_st.settle = '0;
        end else begin
            case (st.mode)
                lpm_pkg::LPM_RUN: begin
                    if (CTRL_WR.wr) begin
                        next_st.ctrl = CTRL_WR.data;
                    end
                    // Capture pin levels as the mode begins
                    next_st.held_p0 = RUN_PINS.p0_out;
                    next_st.held_p0_oe = RUN_PINS.p0_oe;
                    next_st.held_p2 = RUN_PINS.p2_out;
                    if (INSTR_DONE) begin
                        if (bit_of(st.ctrl, lpm_pkg::PDOWN_POS)) begin
                            next_st.mode = lpm_pkg::LPM_PDOWN;
                        end else if (bit_of(st.ctrl, lpm_pkg::IDLE_POS)) begin
                            next_st.mode = lpm_pkg::LPM_IDLE;
                        end
                    end
                end
                lpm_pkg::LPM_IDLE: begin
                    if (IRQ_PENDING) begin
                        next_st.ctrl[lpm_pkg::IDLE_POS] = 1'b0;
                        next_st.mode = lpm_pkg::LPM_RUN;
                    end
                end
                lpm_pkg::LPM_PDOWN: begin
                    // Reset pin needs the oscillator back before it can count
                    if (a_low || b_low || RST_PIN) begin
                        next_st.mode = lpm_pkg::LPM_OSC_START;
                        next_st.settle = '0;
                        // Latch now so a short low pulse cannot strand the exit
                        next_st.wake_a = a_low;
                        next_st.wake_b = b_low;
                    end
                end
                lpm_pkg::LPM_OSC_START: begin
                    if (st.settle != 16'(SETTLE_CYC)) begin
                        next_st.settle = st.settle + 16'h0001;
                    end
                    // First released pin completes the exit
                    if ((st.wake_a && EXT_IRQ_A_N) || (st.wake_b && EXT_IRQ_B_N)) begin
                        next_st.mode = lpm_pkg::LPM_WAKE_DONE;
                    end else begin
                        next_st.wake_a = st.wake_a || a_low;
                        next_st.wake_b = st.wake_b || b_low;
                    end
                    if (!st.wake_a && !st.wake_b) begin
                        next_st.wake_a = a_low;
                        next_st.wake_b = b_low;
                    end
                    // Source gone before anything latched: back to sleep
                    if (!st.wake_a && !st.wake_b && !a_low && !b_low && !RST_PIN) begin
                        next_st.mode = lpm_pkg::LPM_PDOWN;
                    end
                end
                lpm_pkg::LPM_WAKE_DONE: begin
                    // Higher-priority routine wins when both pins woke
                    if (st.wake_a && st.wake_b) begin
                        next_st.wake_pulse_a = !IRQ_B_HIGHER;
                        next_st.wake_pulse_b = IRQ_B_HIGHER;
                    end else begin
                        next_st.wake_pulse_a = st.wake_a;
                        next_st.wake_pulse_b = st.wake_b;
                    end
                    next_st.wake_a = 1'b0;
                    next_st.wake_b = 1'b0;
                    // Registers untouched; only mode bits drop when vectoring
                    next_st.ctrl[lpm_pkg::PDOWN_POS] = 1'b0;
                    next_st.ctrl[lpm_pkg::IDLE_POS] = 1'b0;
                    next_st.mode = lpm_pkg::LPM_RUN;
                end
                default: begin
                    next_st.mode = lpm_pkg::LPM_RUN;
                end
            endcase
        end
        if (IRQ_VECTOR && cpu_running(st.mode) && !rst_done && !CTRL_WR.wr) begin
            next_st.ctrl[lpm_pkg::PDOWN_POS] = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Pin behaviour per mode
    always_comb begin
        PIN_DRIVE = RUN_PINS;
        case (st.mode)
            lpm_pkg::LPM_IDLE: begin
                PIN_DRIVE.ale = 1'b1;
                PIN_DRIVE.pss = 1'b1;
                PIN_DRIVE.p0_out = st.held_p0;
                PIN_DRIVE.p0_oe = EXT_PROG_MEM ? 8'h00 : st.held_p0_oe;
                PIN_DRIVE.p2_out = EXT_PROG_MEM ? P2_ADDR : st.held_p2;
            end
            lpm_pkg::LPM_PDOWN, lpm_pkg::LPM_OSC_START, lpm_pkg::LPM_WAKE_DONE: begin
                PIN_DRIVE.ale = 1'b0;
                PIN_DRIVE.pss = 1'b0;
                PIN_DRIVE.p0_out = st.held_p0;
                PIN_DRIVE.p0_oe = EXT_PROG_MEM ? 8'h00 : st.held_p0_oe;
                PIN_DRIVE.p2_out = st.held_p2;
            end
            default: begin
                PIN_DRIVE = RUN_PINS;
            end
        endcase
    end

    // CPU clock halts in idle and power-down; state held by the gated core
    assign CPU_CLK_EN = cpu_running(st.mode);
    assign PERIPH_CLK_EN = st.mode == lpm_pkg::LPM_RUN || st.mode == lpm_pkg::LPM_IDLE;
    assign OSC_EN = !osc_stopped(st.mode);
    assign MEM_WRITE_BLOCK = !cpu_running(st.mode);
    assign SFR_INIT = st.sfr_init;
    assign CORE_RESET = RST_PIN;
    assign WAKE_IRQ_A = st.wake_pulse_a;
    assign WAKE_IRQ_B = st.wake_pulse_b;
    assign POWER_CTRL_REG = st.ctrl;
    assign MODE = st.mode;
endmodule

/* File: src/lpm_reset_stretch.sv */
// Counts reset hold time in oscillator periods while the oscillator runs
`timescale 1ns/100ps
module lpm_reset_stretch #(
    parameter int HOLD = lpm_pkg::RESET_OSC_PERIODS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic osc_tick,
    input wire logic rst_req,
    output logic rst_done
);
    typedef struct packed {
        logic [7:0] cnt;
        logic done;
    } lpm_rs_state_t;

    lpm_rs_state_t st;
    lpm_rs_state_t next_st;

    always_comb begin
        next_st = st;
        if (!rst_req) begin
            next_st.cnt = 8'h00;
            next_st.done = 1'b0;
        end else if (osc_tick && !st.done) begin
            if (st.cnt == 8'(HOLD - 1)) begin
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rst_done = st.done;
endmodule

/* File: testbench/lpm_core_model.sv */
// Core stand-in: finishes instructions and vectors wake interrupts
`timescale 1ns/100ps
module lpm_core_model (
    input wire logic clk,
    input wire logic cpu_en,
    input wire logic wr,
    input wire logic wake,
    output logic instr_done,
    output logic vector
);
    initial begin
        instr_done = 1'b0;
        vector = 1'b0;
    end
    // Writing instruction ends next cycle, so it is the last one run
    always @(posedge clk) begin
        instr_done <= wr && cpu_en;
        vector <= wake;
    end
endmodule

/* File: testbench/lpm_ctrl_asserts.sv */
// Port assertions for the mode controller
`timescale 1ns/100ps
module lpm_ctrl_asserts (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic INSTR_DONE,
    input wire logic IRQ_PENDING,
    input wire logic EXT_IRQ_A_N,
    input wire logic EXT_IRQ_B_N,
    input wire logic EXT_IRQ_A_EN,
    input wire logic EXT_IRQ_B_EN,
    input wire logic RST_PIN,
    input wire logic [7:0] POWER_CTRL_REG,
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic OSC_EN,
    input wire lpm_pkg::lpm_pins_t PIN_DRIVE,
    input wire logic [2:0] MODE
);
    default clocking @(posedge SYS_CLK); endclocking
    // Pin reset overrides every mode relation
    default disable iff (!RESETN || RST_PIN);
    logic wake;
    assign wake = (EXT_IRQ_A_EN && !EXT_IRQ_A_N) || (EXT_IRQ_B_EN && !EXT_IRQ_B_N);
    pd_entry_a: assert property (
        MODE == 3'h0 && INSTR_DONE && POWER_CTRL_REG[1] |=> MODE == 3'h2) else $error("no power-down entry");
    idle_entry_a: assert property (
        MODE == 3'h0 && INSTR_DONE && POWER_CTRL_REG[1:0] == 2'h1 |=> MODE == 3'h1) else $error("no idle entry");
    clk_gate_a: assert property (
        MODE == 3'h1 |-> !CPU_CLK_EN && PERIPH_CLK_EN) else $error("idle clock gating wrong");
    idle_pins_a: assert property (
        MODE == 3'h1 |-> PIN_DRIVE.ale && PIN_DRIVE.pss) else $error("idle strobes not high");
    pd_pins_a: assert property (
        MODE == 3'h2 |-> !PIN_DRIVE.ale && !PIN_DRIVE.pss && !OSC_EN) else $error("power-down pins wrong");
    idle_exit_a: assert property (
        MODE == 3'h1 && IRQ_PENDING |=> MODE == 3'h0 && !POWER_CTRL_REG[0]) else $error("idle exit wrong");
    pd_hold_a: assert property (
        MODE == 3'h2 && !wake |=> MODE == 3'h2) else $error("power-down left without wake");
    osc_start_a: assert property (
        MODE == 3'h2 && wake |=> MODE == 3'h3 && OSC_EN) else $error("oscillator not restarted");
    wake_done_a: assert property (
        MODE == 3'h4 |=> MODE == 3'h0 && POWER_CTRL_REG[1:0] == 2'h0) else $error("mode bits not cleared");
    cover property (MODE == 3'h1 ##1 MODE == 3'h0);
    cover property (MODE == 3'h3 ##[1:300] MODE == 3'h4);
    cover property (MODE == 3'h2 && !wake);
endmodule
bind lpm_ctrl lpm_ctrl_asserts chk_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .INSTR_DONE(INSTR_DONE),
    .IRQ_PENDING(IRQ_PENDING), .EXT_IRQ_A_N(EXT_IRQ_A_N), .EXT_IRQ_B_N(EXT_IRQ_B_N),
    .EXT_IRQ_A_EN(EXT_IRQ_A_EN), .EXT_IRQ_B_EN(EXT_IRQ_B_EN), .RST_PIN(RST_PIN),
    .POWER_CTRL_REG(POWER_CTRL_REG), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .OSC_EN(OSC_EN), .PIN_DRIVE(PIN_DRIVE), .MODE(MODE));

/* File: testbench/tb_top.sv */
// Bench for the low power mode controller
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    lpm_pkg::lpm_ctrl_wr_t cw = '0;
    lpm_pkg::lpm_pins_t rp = '0;
    lpm_pkg::lpm_pins_t pd;
    logic pend = 1'b0, a_n = 1'b1, b_n = 1'b1, a_en = 1'b0, b_en = 1'b0, b_hi = 1'b0, ext = 1'b0, rst = 1'b0;
    logic [7:0] p2a = 8'h5A;
    logic [7:0] pcr;
    logic [2:0] mode;
    logic idone, vec, cpu_en, per_en, osc_en, wa, wb, sinit, mwb, crst;
    logic sinit_q = 1'b0;
    int num_errors = 0, total_checks = 0, cyc = 0, nwa = 0, nwb = 0, nsi = 0;
    always #2 clk = ~clk;
    lpm_ctrl #(.RESET_HOLD(24)) dut_u (.SYS_CLK(clk), .RESETN(rstn), .CTRL_WR(cw), .INSTR_DONE(idone),
        .IRQ_PENDING(pend), .IRQ_VECTOR(vec), .EXT_IRQ_A_N(a_n), .EXT_IRQ_B_N(b_n), .EXT_IRQ_A_EN(a_en),
        .EXT_IRQ_B_EN(b_en), .IRQ_B_HIGHER(b_hi), .EXT_PROG_MEM(ext), .RST_PIN(rst), .RUN_PINS(rp),
        .P2_ADDR(p2a), .POWER_CTRL_REG(pcr), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .OSC_EN(osc_en),
        .MEM_WRITE_BLOCK(mwb), .SFR_INIT(sinit), .CORE_RESET(crst), .WAKE_IRQ_A(wa), .WAKE_IRQ_B(wb),
        .PIN_DRIVE(pd), .MODE(mode));
    lpm_core_model core_u (.clk(clk), .cpu_en(cpu_en), .wr(cw.wr), .wake(wa | wb), .instr_done(idone),
        .vector(vec));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic write_ctrl(input logic [7:0] d);
        @(negedge clk);
        cw = '{1'b1, d};
        @(negedge clk);
        cw = '0;
    endtask
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 400 && mode !== m; i++) @(negedge clk);
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Pulse counters prove wake and init strobes fire exactly once per wake or reset
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wa === 1'b1) nwa <= nwa + 1;
        if (wb === 1'b1) nwb <= nwb + 1;
        // Init stays up while the pin is held, so count its rising edges
        sinit_q <= sinit;
        if (sinit === 1'b1 && sinit_q !== 1'b1) nsi <= nsi + 1;
        if (cyc == 4000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        check("ctrl", pcr, 8'h00);
        rp = '{1'b0, 1'b0, 8'h3C, 8'hFF, 8'hA5};
        write_ctrl(8'h0D);
        wait_mode(3'h1);
        rp = '0;
        @(negedge clk);
        check("clk en", {6'h00, cpu_en, per_en}, 8'h01);
        check("strobes", {6'h00, pd.ale, pd.pss}, 8'h03);
        check("p0 held", pd.p0_out, 8'h3C);
        check("p2 held", pd.p2_out, 8'hA5);
        check("ram guard", {7'h00, mwb}, 8'h01);
        pend = 1'b1;
        wait_mode(3'h0);
        pend = 1'b0;
        check("idle exit ctrl", pcr, 8'h0C);
        check("ram free", {7'h00, mwb}, 8'h00);
        ext = 1'b1;
        rp = '{1'b1, 1'b1, 8'h3C, 8'hFF, 8'hA5};
        write_ctrl(8'h05);
        wait_mode(3'h1);
        check("p2 addr", pd.p2_out, p2a);
        check("p0 float", pd.p0_oe, 8'h00);
        // Hold beyond two machine cycles of oscillator periods
        rst = 1'b1;
        repeat (30) @(negedge clk);
        check("core reset", {7'h00, crst}, 8'h01);
        rst = 1'b0;
        @(negedge clk);
        check("reset mode", 8'(mode), 8'h00);
        check("reset ctrl", pcr, 8'h00);
        check("init pulses", 8'(nsi), 8'h01);
        ext = 1'b0;
        a_en = 1'b1;
        write_ctrl(8'h06);
        wait_mode(3'h2);
        check("osc off", {6'h00, osc_en, pd.ale}, 8'h00);
        b_n = 1'b0;
        repeat (3) @(negedge clk);
        check("disabled pin", 8'(mode), 8'h02);
        b_n = 1'b1;
        a_n = 1'b0;
        repeat (lpm_pkg::WAKE_SETTLE_CYC + 2) @(negedge clk);
        check("osc restart", {7'h00, osc_en}, 8'h01);
        a_n = 1'b1;
        wait_mode(3'h0);
        repeat (2) @(negedge clk);
        check("pd exit ctrl", pcr, 8'h04);
        check("wake a", 8'(nwa), 8'h01);
        b_en = 1'b1;
        b_hi = 1'b1;
        write_ctrl(8'h0B);
        wait_mode(3'h2);
        a_n = 1'b0;
        b_n = 1'b0;
        repeat (lpm_pkg::WAKE_SETTLE_CYC + 2) @(negedge clk);
        a_n = 1'b1;
        wait_mode(3'h0);
        b_n = 1'b1;
        repeat (5) @(negedge clk);
        check("both exit mode", 8'(mode), 8'h00);
        check("both exit ctrl", pcr, 8'h08);
        check("wake b", 8'(nwb), 8'h01);
        check("wake a again", 8'(nwa), 8'h01);
        write_ctrl(8'h02);
        wait_mode(3'h2);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        check("pd reset osc", {7'h00, osc_en}, 8'h01);
        repeat (lpm_pkg::WAKE_SETTLE_CYC) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("pd reset mode", 8'(mode), 8'h00);
        check("pd reset ctrl", pcr, 8'h00);
        check("init pulses again", 8'(nsi), 8'h02);
        conclude();
    end
endmodule
